// File: ldis_input_select.sv
// Purpose: Picks the input byte of two current converters from tables or registers
// Assumes: Wishbone classic slave, 32-bit data, low byte carries each register
// Notes: Supply indications and conversion results arrive synchronous to clk_i
`timescale 1ns/10ps

// Behaviour
// RQ1 - Two 64-byte tables, one per converter
// RQ2 - Selected table row feeds its converter
// RQ3 - Row address is base plus index
// RQ4 - Default row index is converter result
// RQ5 - Bypass takes row from control register bits
// RQ6 - Channel one three-way source select
// RQ7 - Channel two same three-way select
// RQ8 - Shared result, channels otherwise independent
// RQ9 - Direct mode drives full control byte
// RQ10 - Per-channel source/sink direction bit
// RQ11 - Recall settings, then power analog
// RQ12 - Enable converter after supply good
// RQ13 - Apply table bytes after four matches
// RQ14 - Converter inputs zero until first apply
// RQ15 - Filter off needs single conversion
// RQ16 - Recalled selects govern first update
// RQ17 - Result is 6-bit binary code
// RQ18 - Published result filters four identical conversions
// RQ19 - Registered converter bytes track all changes
module ldis_input_select #(
    parameter int unsigned ROWS = ldis_pkg::TBL_ROWS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Power sequencing and nonvolatile recall
    input wire logic first_supply_threshold_i,
    input wire logic converter_supply_good_i,
    input wire logic [7:0] nv_ctrl_i,
    input wire logic [7:0] nv_row_one_i,
    input wire logic [7:0] nv_row_two_i,
    input wire logic [7:0] nv_byte_one_i,
    input wire logic [7:0] nv_byte_two_i,
    input wire logic [7:0] nv_sel_i,
    output logic analog_power_o,
    output logic adc_enable_o,
    // Shared temperature converter
    input wire logic [ldis_pkg::ROW_W-1:0] adc_result_i,
    input wire logic adc_done_i,
    // Current converters
    output logic [ldis_pkg::BYTE_W-1:0] current_out_one_byte_o,
    output logic [ldis_pkg::BYTE_W-1:0] current_out_two_byte_o,
    output logic output_one_direction_o,
    output logic output_two_direction_o
);
    import ldis_pkg::*;

    // Decode a memory address into a table hit
    function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (a >= lo) && (a < hi);
    endfunction

    // Register copies of the nonvolatile settings
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] row_one_r, row_one_nxt;
    logic [7:0] row_two_r, row_two_nxt;
    logic [7:0] byte_one_r, byte_one_nxt;
    logic [7:0] byte_two_r, byte_two_nxt;
    logic [7:0] sel_r, sel_nxt;
    // Bus handshake
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    // Sequencer
    ldis_seq_e seq_r, seq_nxt;
    // Result filter
    logic [ROW_W-1:0] last_r, last_nxt;
    logic [ROW_W-1:0] pub_r, pub_nxt;
    logic [2:0] match_r, match_nxt;
    logic pub_valid_r, pub_valid_nxt;
    // Converter bytes
    logic [7:0] out_one_r, out_one_nxt;
    logic [7:0] out_two_r, out_two_nxt;
    logic apply_r, apply_nxt;

    // Bus address as a memory byte address
    logic [8:0] mem_addr;
    logic bus_req, bus_wr;
    logic hit_one, hit_two;
    logic [ROW_W-1:0] bus_row;
    assign mem_addr = adr_i[10:2];
    assign bus_req = cyc_i && stb_i && !ack_r;
    // Writes commit only while ack stands, the edge the master takes it
    assign bus_wr = ack_r && cyc_i && stb_i && we_i && sel_i[0];
    assign hit_one = in_range(mem_addr, TBL_ONE_BASE, TBL_TWO_BASE); // [RQ3]
    assign hit_two = in_range(mem_addr, TBL_TWO_BASE, TBL_END);
    assign bus_row = hit_one ? 6'(mem_addr - TBL_ONE_BASE) : 6'(mem_addr - TBL_TWO_BASE);

    // Row index per table: converter result or software row
    logic [ROW_W-1:0] idx_one, idx_two;
    assign idx_one = sel_r[SEL_ROW_ONE_BIT] ? row_one_r[ROW_W-1:0] : pub_r; // [RQ4] [RQ5]
    assign idx_two = sel_r[SEL_ROW_TWO_BIT] ? row_two_r[ROW_W-1:0] : pub_r; // [RQ5] [RQ8]

    // Each table: port A serves the bus, port B the converter path
    logic [7:0] t1_bus, t1_conv, t2_bus, t2_conv;
    ldis_table_mem #(.DEPTH(ROWS), .AW(ROW_W), .DW(BYTE_W)) u_table_one ( // [RQ1]
        .clk_i(clk_i),
        .we_i(bus_wr && hit_one),
        .waddr_i(bus_row),
        .wdata_i(dat_i[7:0]),
        .raddr_a_i(bus_row),
        .rdata_a_o(t1_bus),
        .raddr_b_i(idx_one),
        .rdata_b_o(t1_conv)
    );
    ldis_table_mem #(.DEPTH(ROWS), .AW(ROW_W), .DW(BYTE_W)) u_table_two ( // [RQ1]
        .clk_i(clk_i),
        .we_i(bus_wr && hit_two),
        .waddr_i(bus_row),
        .wdata_i(dat_i[7:0]),
        .raddr_a_i(bus_row),
        .rdata_a_o(t2_bus),
        .raddr_b_i(idx_two),
        .rdata_b_o(t2_conv)
    );

    // Two-cycle bus answer so the registered table read is ready
    logic pend_r, pend_nxt;

    // Register file and bus next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        row_one_nxt = row_one_r;
        row_two_nxt = row_two_r;
        byte_one_nxt = byte_one_r;
        byte_two_nxt = byte_two_r;
        sel_nxt = sel_r;
        pend_nxt = bus_req && !pend_r;
        ack_nxt = pend_r && cyc_i && stb_i;
        dat_nxt = 32'h00000000;
        if (seq_r == SEQ_RECALL) begin
            // Settings copied before analog power is allowed
            ctrl_nxt = nv_ctrl_i; // [RQ11]
            row_one_nxt = nv_row_one_i;
            row_two_nxt = nv_row_two_i;
            byte_one_nxt = nv_byte_one_i;
            byte_two_nxt = nv_byte_two_i;
            sel_nxt = nv_sel_i; // [RQ16]
            pend_nxt = 1'b0;
            ack_nxt = 1'b0;
        end else if (pend_r && cyc_i && stb_i) begin
            // Read mux; unmapped addresses read zero
            case (mem_addr)
                REG_CTRL0: dat_nxt = {24'h000000, ctrl_r};
                REG_ROW_ONE: dat_nxt = {24'h000000, row_one_r};
                REG_ROW_TWO: dat_nxt = {24'h000000, row_two_r};
                REG_BYTE_ONE: dat_nxt = {24'h000000, byte_one_r};
                REG_BYTE_TWO: dat_nxt = {24'h000000, byte_two_r};
                REG_SEL: dat_nxt = {24'h000000, sel_r};
                REG_STATUS: dat_nxt = {26'h0000000, pub_r}; // [RQ17]
                default: begin
                    if (hit_one) begin
                        dat_nxt = {24'h000000, t1_bus};
                    end else if (hit_two) begin
                        dat_nxt = {24'h000000, t2_bus};
                    end
                end
            endcase
        end
        // Writes land at the edge where the master samples ack; recall wins
        if (bus_wr && seq_r != SEQ_RECALL) begin
            case (mem_addr)
                REG_CTRL0: ctrl_nxt = dat_i[7:0];
                REG_ROW_ONE: row_one_nxt = dat_i[7:0];
                REG_ROW_TWO: row_two_nxt = dat_i[7:0];
                REG_BYTE_ONE: byte_one_nxt = dat_i[7:0];
                REG_BYTE_TWO: byte_two_nxt = dat_i[7:0];
                REG_SEL: sel_nxt = dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Power-up sequencer next state
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_RECALL: begin
                if (first_supply_threshold_i) begin
                    seq_nxt = SEQ_ANALOG; // [RQ11]
                end
            end
            SEQ_ANALOG: seq_nxt = SEQ_WAIT_OK;
            SEQ_WAIT_OK: begin
                if (converter_supply_good_i) begin
                    seq_nxt = SEQ_SETTLE; // [RQ12]
                end
            end
            SEQ_SETTLE: begin
                // Direct bytes need no conversion; table paths wait for a result
                if (pub_valid_r || (sel_r[SEL_DIR_ONE_BIT] && sel_r[SEL_DIR_TWO_BIT])) begin
                    seq_nxt = SEQ_RUN; // [RQ13] [RQ16]
                end
            end
            SEQ_RUN: seq_nxt = SEQ_RUN;
            default: seq_nxt = SEQ_RECALL;
        endcase
        // Supply loss restarts the whole sequence
        if (!first_supply_threshold_i) begin
            seq_nxt = SEQ_RECALL;
        end
    end

    // Result filter next values
    always_comb begin
        last_nxt = last_r;
        match_nxt = match_r;
        pub_nxt = pub_r;
        pub_valid_nxt = pub_valid_r;
        if (!adc_enable_o) begin
            match_nxt = 3'h0;
            pub_valid_nxt = 1'b0;
        end else if (adc_done_i) begin
            last_nxt = adc_result_i;
            if (match_r == 3'h0 || adc_result_i != last_r) begin
                match_nxt = 3'h1;
            end else if (match_r < 3'(FILT_COUNT)) begin
                match_nxt = match_r + 3'h1;
            end
            // Publish on every conversion or after four identical ones
            if (ctrl_r[CTRL_FILT_OFF_BIT]) begin
                pub_nxt = adc_result_i; // [RQ15] [RQ18]
                pub_valid_nxt = 1'b1;
            end else if (match_r == 3'(FILT_COUNT - 1) && adc_result_i == last_r) begin
                pub_nxt = adc_result_i; // [RQ13] [RQ18]
                pub_valid_nxt = 1'b1;
            end
        end
    end

    // Converter byte next values
    always_comb begin
        apply_nxt = (seq_r == SEQ_RUN);
        out_one_nxt = CONV_RESET_BYTE; // [RQ14]
        out_two_nxt = CONV_RESET_BYTE; // [RQ14]
        // Table data lags the index one cycle, so wait one cycle in RUN;
        // leaving RUN zeroes both bytes at once, as on a fresh power-up
        if (apply_r && seq_nxt == SEQ_RUN) begin
            out_one_nxt = sel_r[SEL_DIR_ONE_BIT] ? byte_one_r : t1_conv; // [RQ2] [RQ6] [RQ9]
            out_two_nxt = sel_r[SEL_DIR_TWO_BIT] ? byte_two_r : t2_conv; // [RQ7] [RQ9]
        end
    end

    // State registers; recalled values are loaded in RECALL, not by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= REG_RESET;
            row_one_r <= REG_RESET;
            row_two_r <= REG_RESET;
            byte_one_r <= REG_RESET;
            byte_two_r <= REG_RESET;
            sel_r <= REG_RESET;
            ack_r <= 1'b0;
            pend_r <= 1'b0;
            dat_r <= 32'h00000000;
            seq_r <= SEQ_RECALL;
            last_r <= 6'h00;
            pub_r <= 6'h00;
            match_r <= 3'h0;
            pub_valid_r <= 1'b0;
            out_one_r <= CONV_RESET_BYTE;
            out_two_r <= CONV_RESET_BYTE;
            apply_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            row_one_r <= row_one_nxt;
            row_two_r <= row_two_nxt;
            byte_one_r <= byte_one_nxt;
            byte_two_r <= byte_two_nxt;
            sel_r <= sel_nxt;
            ack_r <= ack_nxt;
            pend_r <= pend_nxt;
            dat_r <= dat_nxt;
            seq_r <= seq_nxt;
            last_r <= last_nxt;
            pub_r <= pub_nxt;
            match_r <= match_nxt;
            pub_valid_r <= pub_valid_nxt;
            out_one_r <= out_one_nxt; // [RQ19]
            out_two_r <= out_two_nxt; // [RQ19]
            apply_r <= apply_nxt;
        end
    end

    // Outputs
    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign analog_power_o = (seq_r != SEQ_RECALL); // [RQ11]
    assign adc_enable_o = (seq_r == SEQ_SETTLE) || (seq_r == SEQ_RUN); // [RQ12]
    assign current_out_one_byte_o = out_one_r;
    assign current_out_two_byte_o = out_two_r;
    assign output_one_direction_o = ctrl_r[CTRL_DIR_ONE_BIT]; // [RQ10]
    assign output_two_direction_o = ctrl_r[CTRL_DIR_TWO_BIT]; // [RQ10]
endmodule

// File: ldis_pkg.sv
// Purpose: Shared constants for the table-driven converter input select block
// Assumes: 40 MHz system clock, synchronous active-high reset
// Notes: Byte addresses are Wishbone word addresses (bus address bits [10:2]), one register per word
package ldis_pkg;
    // Table geometry
    localparam int unsigned TBL_ROWS = 64;
    localparam int unsigned ROW_W = 6;
    localparam int unsigned BYTE_W = 8;
    // Memory byte address bases of the two tables
    localparam logic [8:0] TBL_ONE_BASE = 9'h090;
    localparam logic [8:0] TBL_TWO_BASE = 9'h0D0;
    localparam logic [8:0] TBL_END = 9'h110;
    // Register word byte addresses (bus address bits [10:2] map the memory address)
    localparam logic [8:0] REG_CTRL0 = 9'h080;
    localparam logic [8:0] REG_ROW_ONE = 9'h081;
    localparam logic [8:0] REG_ROW_TWO = 9'h082;
    localparam logic [8:0] REG_BYTE_ONE = 9'h084;
    localparam logic [8:0] REG_BYTE_TWO = 9'h085;
    localparam logic [8:0] REG_SEL = 9'h086;
    localparam logic [8:0] REG_STATUS = 9'h087;
    // Field positions in the control register
    localparam int unsigned CTRL_DIR_ONE_BIT = 0;
    localparam int unsigned CTRL_DIR_TWO_BIT = 1;
    localparam int unsigned CTRL_FILT_OFF_BIT = 2;
    // Field positions in the select register
    localparam int unsigned SEL_ROW_ONE_BIT = 0;
    localparam int unsigned SEL_DIR_ONE_BIT = 1;
    localparam int unsigned SEL_ROW_TWO_BIT = 2;
    localparam int unsigned SEL_DIR_TWO_BIT = 3;
    // Reset values
    localparam logic [7:0] CONV_RESET_BYTE = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Filter length: identical conversions needed before publishing
    localparam int unsigned FILT_COUNT = 4;
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_RECALL = 3'b000,
        SEQ_ANALOG = 3'b001,
        SEQ_WAIT_OK = 3'b010,
        SEQ_SETTLE = 3'b011,
        SEQ_RUN = 3'b100
    } ldis_seq_e;
endpackage

// File: ldis_table_mem.sv
// Purpose: Two-port byte table memory with one registered read port per port
// Assumes: Single clock; write through port A only
// Notes: Read data comes out one cycle after the address
`timescale 1ns/10ps
module ldis_table_mem #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned AW = 6,
    parameter int unsigned DW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_a_i,
    output logic [DW-1:0] rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic [DW-1:0] rdata_b_o
);
    // Storage; no reset or initial value, so contents are unknown until written
    logic [DW-1:0] mem_r [DEPTH];

    // Write and registered reads
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_a_o <= mem_r[raddr_a_i];
        rdata_b_o <= mem_r[raddr_b_i];
    end
endmodule

// File: ldis_input_select_sva.sv
// Purpose: Port-level checks for the converter input select block
// Assumes: One clock, synchronous active-high reset
// Notes: The ack latency check applies only once the sequencer has left recall
`timescale 1ns/10ps
module ldis_input_select_sva #(
    parameter int unsigned ROWS = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic first_supply_threshold_i,
    input wire logic converter_supply_good_i,
    input wire logic analog_power_o,
    input wire logic adc_enable_o,
    input wire logic [7:0] current_out_one_byte_o,
    input wire logic [7:0] current_out_two_byte_o
);
    // Single domain, so clock and reset are stated once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Converter bytes stay zero until the converter runs
    out_zero_a: assert property (!adc_enable_o |->
        (current_out_one_byte_o == 8'h00 && current_out_two_byte_o == 8'h00))
        else $error("converter byte left zero early");
    // Supply below first threshold keeps analog off
    power_order_a: assert property (!first_supply_threshold_i |=> !analog_power_o)
        else $error("analog powered without supply");
    // Converter enable follows supply good and analog power
    adc_good_a: assert property ($rose(adc_enable_o) |-> $past(converter_supply_good_i))
        else $error("converter enabled without supply good");
    adc_after_power_a: assert property (adc_enable_o |-> analog_power_o)
        else $error("converter enabled before analog power");
    // Fixed answer latency keeps the register path predictable
    ack_delay_a: assert property ($rose(cyc_i && stb_i) && analog_power_o |-> ##2 ack_o)
        else $error("ack not two cycles after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_req_a: assert property (ack_o |-> cyc_i && stb_i)
        else $error("ack without request");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
endmodule

bind ldis_input_select ldis_input_select_sva #(.ROWS(ROWS)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .first_supply_threshold_i(first_supply_threshold_i),
    .converter_supply_good_i(converter_supply_good_i), .analog_power_o(analog_power_o),
    .adc_enable_o(adc_enable_o), .current_out_one_byte_o(current_out_one_byte_o),
    .current_out_two_byte_o(current_out_two_byte_o));

// File: ldis_adc_model.sv
// Purpose: Behavioural shared temperature converter
// Assumes: One conversion every four cycles while enabled
// Notes: Result is meaningful only while done is high
`timescale 1ns/10ps
module ldis_adc_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [5:0] level_i,
    output logic [5:0] result_o,
    output logic done_o
);
    logic [1:0] div_r; // Conversion time counter
    // Converts only when enabled; stale codes toggle so they never pass as valid
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            div_r <= 2'h0;
            done_o <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            done_o <= (div_r == 2'h3);
        end
        result_o <= rst_i ? 6'h15 : (enable_i && div_r == 2'h3) ? level_i : ~result_o;
    end
endmodule

// File: ldis_input_select_bench.sv
// Purpose: Self-checking bench for the converter input select block
// Assumes: 40 MHz clock, tables survive reset
// Notes: Three power-ups cover default, filter off and direct recall
`timescale 1ns/10ps
module ldis_input_select_bench;
    import ldis_pkg::*;
    logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, thr = 1'b0;
    logic good = 1'b0, done, ack_o, apwr, aen, dir1, dir2;
    logic [31:0] adr = 32'h0, dat = 32'h0, rd, dat_o;
    logic [7:0] nctrl = 8'h00, nsel = 8'h00, out1, out2;
    logic [5:0] res, lvl = 6'h05;
    int mismatches = 0, num_checks = 0, dcnt = 0;
    // Mode rows: select value, byte one, byte two
    logic [23:0] rows [9] = '{24'h001525, 24'h011A25, 24'h02C325, 24'h03C325,
        24'h04152B, 24'h08155E, 24'h0C155E, 24'h051A2B, 24'h0AC35E};
    // Table writes: address, byte
    logic [16:0] tw [6] = '{{9'h095, 8'h15}, {9'h0CF, 8'h1A}, {9'h0D5, 8'h25},
        {9'h0D0, 8'h2B}, {9'h096, 8'h77}, {9'h0D6, 8'h88}};
    ldis_input_select DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .first_supply_threshold_i(thr), .converter_supply_good_i(good),
        .nv_ctrl_i(nctrl), .nv_row_one_i(8'h3F), .nv_row_two_i(8'h00),
        .nv_byte_one_i(8'hC3), .nv_byte_two_i(8'h5E), .nv_sel_i(nsel),
        .analog_power_o(apwr), .adc_enable_o(aen), .adc_result_i(res), .adc_done_i(done),
        .current_out_one_byte_o(out1), .current_out_two_byte_o(out2),
        .output_one_direction_o(dir1), .output_two_direction_o(dir2));
    ldis_adc_model adc (.clk_i(clk_i), .rst_i(rst_i), .enable_i(aen), .level_i(lvl),
        .result_o(res), .done_o(done));
    // 25 ns clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Conversions seen since supply good
    always @(posedge clk_i) dcnt <= (rst_i || !good) ? 0 : dcnt + int'(done);
    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t saw %h want %h", $time, s, e);
        end
    endtask
    // Classic cycle: request held until ack is sampled
    task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {21'h0, a, 2'b00};
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            mismatches++;
            give_verdict();
        end
    endtask
    // Reset, supply ramp, table load, then wait for first converter byte
    task automatic power_up(input logic [7:0] c, input logic [7:0] s, input int n,
        input logic [15:0] e);
        int k;
        rst_i <= 1'b1;
        thr <= 1'b0;
        good <= 1'b0;
        nctrl <= c;
        nsel <= s;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(32'(apwr), 32'h0);
        thr <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(32'({apwr, aen}), 32'h2);
        foreach (tw[i]) wb(1'b1, tw[i][16:8], tw[i][7:0]);
        chk(32'({out1, out2}), 32'h0);
        good <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (out1 === 8'h00 && k < 300);
        if (k >= 300) begin
            mismatches++;
            give_verdict();
        end
        if (n >= 0) chk(32'(dcnt), 32'(n));
        chk(32'({out1, out2}), 32'(e));
    endtask
    initial begin
        @(posedge clk_i);
        power_up(8'h00, 8'h00, 4, 16'h1525);
        chk(32'({dir1, dir2}), 32'h0);
        wb(1'b0, REG_ROW_ONE, 8'h00);
        chk(rd, 32'h3F);
        wb(1'b0, REG_STATUS, 8'h00);
        chk(rd, 32'h05);
        wb(1'b0, 9'h088, 8'h00);
        chk(rd, 32'h0);
        // Each source per channel with the other on result, then both on row and both direct
        foreach (rows[i]) begin
            wb(1'b1, REG_SEL, rows[i][23:16]);
            repeat (4) @(posedge clk_i);
            chk(32'({out1, out2}), 32'(rows[i][15:0]));
        end
        // Direct byte rewritten while selected
        wb(1'b1, REG_BYTE_ONE, 8'h6D);
        repeat (4) @(posedge clk_i);
        chk(32'(out1), 32'h6D);
        // Converter path follows a new filtered result
        wb(1'b1, REG_SEL, 8'h00);
        lvl <= 6'h06;
        // Fewer than four new conversions must not move the result
        repeat (4) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 8'h00);
        chk(rd, 32'h05);
        repeat (32) @(posedge clk_i);
        chk(32'({out1, out2}), 32'h7788);
        wb(1'b1, REG_CTRL0, 8'h02);
        chk(32'({dir1, dir2}), 32'h1);
        power_up(8'h05, 8'h00, 1, 16'h7788);
        chk(32'({dir1, dir2}), 32'h2);
        power_up(8'h00, 8'h0A, -1, 16'hC35E);
        // Supply dip without reset: bytes drop to zero, then recover
        thr <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(32'({apwr, out1, out2}), 32'h0);
        thr <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(32'({out1, out2}), 32'hC35E);
        give_verdict();
    end
endmodule
